// File: mpc_pkg.sv
package mpc_pkg;
  // register offsets on the 8-bit register port
  localparam logic [7:0] MPC_OFS_PIN_TWO = 8'h63;
  localparam logic [7:0] MPC_OFS_REUSE = 8'h64;
  localparam logic [7:0] MPC_OFS_AUX = 8'h6E;
  // values after reset and writable bits per register
  localparam logic [7:0] MPC_PIN_TWO_RST = 8'h00;
  localparam logic [7:0] MPC_REUSE_RST = 8'h00;
  localparam logic [7:0] MPC_AUX_RST = 8'h00;
  localparam logic [7:0] MPC_PIN_TWO_WMASK = 8'hFA;
  localparam logic [7:0] MPC_REUSE_WMASK = 8'hEE;
  localparam logic [7:0] MPC_AUX_WMASK = 8'h01;
  // field positions in multipurpose_pin_two_control
  localparam int MPC_FUNC_HI = 7;
  localparam int MPC_FUNC_LO = 4;
  localparam int MPC_GP_OUT_BIT = 3;
  localparam int MPC_GP_IN_BIT = 2;
  localparam int MPC_DUR_BIT = 1;
  // field positions in bus_pin_reuse_control
  localparam int MPC_DATA_ROLE_HI = 7;
  localparam int MPC_DATA_ROLE_LO = 6;
  localparam int MPC_DATA_OUT_BIT = 5;
  localparam int MPC_DATA_IN_BIT = 4;
  localparam int MPC_CLK_ROLE_HI = 3;
  localparam int MPC_CLK_ROLE_LO = 2;
  localparam int MPC_CLK_OUT_BIT = 1;
  localparam int MPC_CLK_IN_BIT = 0;
  // field position in the auxiliary register: 1 drives the bit clock out
  localparam int MPC_BCLK_DIR_BIT = 0;
  // multipurpose pin function codes
  localparam logic [3:0] MPC_F_DISABLED = 4'h0;
  localparam logic [3:0] MPC_F_RESERVED = 4'h1;
  localparam logic [3:0] MPC_F_JACK_IRQ = 4'h2;
  localparam logic [3:0] MPC_F_GP_IN = 4'h3;
  localparam logic [3:0] MPC_F_GP_OUT = 4'h4;
  localparam logic [3:0] MPC_F_DMIC_A = 4'h5;
  localparam logic [3:0] MPC_F_DMIC_B = 4'h6;
  localparam logic [3:0] MPC_F_DMIC_C = 4'h7;
  localparam logic [3:0] MPC_F_BCLK = 4'h8;
  localparam logic [3:0] MPC_F_HS_BP = 4'h9;
  localparam logic [3:0] MPC_F_ALL4 = 4'hA;
  localparam logic [3:0] MPC_F_SC_AGC = 4'hB;
  localparam logic [3:0] MPC_F_HS_BP_SC = 4'hC;
  localparam logic [3:0] MPC_F_AGC = 4'hD;
  localparam logic [3:0] MPC_F_UNLISTED = 4'hE;
  localparam logic [3:0] MPC_F_BP = 4'hF;
  // control-bus pin roles
  localparam logic [1:0] MPC_ROLE_NONE = 2'h0;
  localparam logic [1:0] MPC_ROLE_IN = 2'h1;
  localparam logic [1:0] MPC_ROLE_OUT = 2'h2;
  // interrupt pulse timing
  localparam int MPC_CLK_PERIOD_NS = 10;
  localparam int MPC_PULSE_NS = 2_000_000;
  localparam int MPC_JACK_PULSE_NS = 1_750_000;
  localparam int MPC_PULSE_CYCLES = MPC_PULSE_NS / MPC_CLK_PERIOD_NS;
  localparam int MPC_JACK_PULSE_CYCLES = MPC_JACK_PULSE_NS / MPC_CLK_PERIOD_NS;
  localparam int MPC_CNT_W = 18;
  typedef enum logic [1:0] {MPC_ST_IDLE, MPC_ST_PULSE, MPC_ST_GAP} mpc_irq_state_e;
endpackage

// File: mpc_pin_control.sv
`timescale 1ns/1ps
// Summary of operation
// - function field resets to 0000 (pin disabled); 0011 makes the pin a general-purpose input.
// - code 0010 drives the jack detect interrupt, active high, about 1.75 ms.
// - digital-microphone codes 0101-0111 take pin data on both mic clock edges.
// - code 1000 carries the serial bit clock, direction programmable.
// - code 1001 outputs headset-detect OR button-press.
// - code 1010 outputs OR of headset, button, short-circuit and noise detect.
// - code 1011 outputs short-circuit OR noise detect.
// - code 1100 outputs headset OR button OR short-circuit.
// - code 1101 outputs noise detect only; 1111 outputs button press only.
// - as general-purpose output the pin drives control bit D3, reset 0.
// - read-only bit D2 returns the present pin level.
// - with D1 at 0 each interrupt is one high pulse of about 2 ms, or about 1.75 ms for code 0010.
// - with D1 at 1 pulses repeat until the interrupt flag register is read.
// - data-line role field: 00 unused, 01 input, 10 output, 11 never written.
// - control-bus pins only pull low; high comes from the external pullup.
// - data-line output bit 0 pulls low, 1 releases the pin.
// - as input, read-only bit D4 reports the data-line level.
// - clock-line role field: 00 unused, 01 input, 10 output, 11 never written.
// - clock-line output bit D1 pulls low or releases; D0 reports its level.
// - the bus pin reuse only acts in SPI mode; otherwise bus function stays.
module mpc_pin_control #(
  parameter int unsigned PULSE_CYCLES = mpc_pkg::MPC_PULSE_CYCLES,
  parameter int unsigned JACK_PULSE_CYCLES = mpc_pkg::MPC_JACK_PULSE_CYCLES
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic headset_irq_in,
  input wire logic button_irq_in,
  input wire logic short_irq_in,
  input wire logic noise_irq_in,
  input wire logic irq_flags_read_in,
  input wire logic bclk_int_in,
  output logic bclk_ext_out,
  input wire logic dmic_clk_in,
  output logic dmic_rise_data_out,
  output logic dmic_fall_data_out,
  output logic dmic_valid_out,
  input wire logic multipurpose_pin_two_in,
  output logic multipurpose_pin_two_out,
  output logic multipurpose_pin_two_oe_out,
  input wire logic spi_select_in,
  input wire logic bus_data_pull_in,
  input wire logic bus_clk_pull_in,
  input wire logic data_pin_in,
  output logic data_pin_out,
  output logic data_pin_oe_out,
  input wire logic clk_pin_in,
  output logic clk_pin_out,
  output logic clk_pin_oe_out
);
  import mpc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] pin_two_reg;
  logic [7:0] reuse_reg;
  logic [7:0] aux_reg;
  logic [7:0] rdata;
  logic [7:0] next_pin_two_reg;
  logic [7:0] next_reuse_reg;
  logic [7:0] next_aux_reg;
  logic [7:0] next_rdata;
  logic [3:0] func;
  logic [1:0] od_pin_in;
  logic [1:0] od_level;

  assign func = pin_two_reg[MPC_FUNC_HI:MPC_FUNC_LO];
  assign od_pin_in = {clk_pin_in, data_pin_in};

  always_comb begin
    next_pin_two_reg = pin_two_reg;
    next_reuse_reg = reuse_reg;
    next_aux_reg = aux_reg;
    next_rdata = 8'h00;
    // reserved bits (pin register D0, aux register D7-D1) and read-only bits are masked out of every write
    if (reg_wr_in) begin
      case (reg_addr_in)
        MPC_OFS_PIN_TWO: next_pin_two_reg = reg_wdata_in & MPC_PIN_TWO_WMASK;
        MPC_OFS_REUSE: next_reuse_reg = reg_wdata_in & MPC_REUSE_WMASK;
        MPC_OFS_AUX: next_aux_reg = reg_wdata_in & MPC_AUX_WMASK;
        default: ;
      endcase
    end
    if (reg_rd_in) begin
      case (reg_addr_in)
        MPC_OFS_PIN_TWO: begin
          next_rdata = pin_two_reg;
          next_rdata[MPC_GP_IN_BIT] = multipurpose_pin_two_in;
        end
        MPC_OFS_REUSE: begin
          next_rdata = reuse_reg;
          next_rdata[MPC_DATA_IN_BIT] = od_level[0];
          next_rdata[MPC_CLK_IN_BIT] = od_level[1];
        end
        MPC_OFS_AUX: next_rdata = aux_reg;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pin_two_reg <= MPC_PIN_TWO_RST;
      reuse_reg <= MPC_REUSE_RST;
      aux_reg <= MPC_AUX_RST;
      rdata <= 8'h00;
    end else begin
      pin_two_reg <= next_pin_two_reg;
      reuse_reg <= next_reuse_reg;
      aux_reg <= next_aux_reg;
      rdata <= next_rdata;
    end
  end

  assign reg_rdata_out = rdata;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt source selection and pulse generator
  mpc_irq_state_e state;
  mpc_irq_state_e next_state;
  logic [MPC_CNT_W-1:0] cnt;
  logic [MPC_CNT_W-1:0] next_cnt;
  logic [MPC_CNT_W-1:0] pulse_len;
  logic src_prev;
  logic next_src_prev;
  logic pending;
  logic next_pending;
  logic irq_func;
  logic irq_src;
  logic irq_event;
  logic repeat_mode;
  logic keep_going;

  assign repeat_mode = pin_two_reg[MPC_DUR_BIT];

  always_comb begin
    irq_func = 1'b1;
    irq_src = 1'b0;
    case (func)
      MPC_F_JACK_IRQ: irq_src = headset_irq_in;
      MPC_F_HS_BP: irq_src = headset_irq_in | button_irq_in;
      MPC_F_ALL4: irq_src = headset_irq_in | button_irq_in | short_irq_in | noise_irq_in;
      MPC_F_SC_AGC: irq_src = short_irq_in | noise_irq_in;
      MPC_F_HS_BP_SC: irq_src = headset_irq_in | button_irq_in | short_irq_in;
      MPC_F_AGC: irq_src = noise_irq_in;
      MPC_F_BP: irq_src = button_irq_in;
      default: irq_func = 1'b0;
    endcase
  end

  // the jack detect code has its own shorter pulse
  assign pulse_len = (func == MPC_F_JACK_IRQ) ? MPC_CNT_W'(JACK_PULSE_CYCLES - 1) : MPC_CNT_W'(PULSE_CYCLES - 1);
  assign irq_event = irq_func & irq_src & ~src_prev;
  // an event in the cycle of the flag read wins over the read
  assign keep_going = repeat_mode & (irq_event | (pending & ~irq_flags_read_in));

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_src_prev = irq_src;
    next_pending = irq_event | (pending & ~irq_flags_read_in);
    case (state)
      MPC_ST_IDLE: begin
        if (irq_event) begin
          next_state = MPC_ST_PULSE;
          next_cnt = pulse_len;
        end
      end
      MPC_ST_PULSE: begin
        if (!irq_func) begin
          next_state = MPC_ST_IDLE;
        end else if (cnt != '0) begin
          next_cnt = cnt - 1'b1;
        end else if (keep_going) begin
          next_state = MPC_ST_GAP;
          next_cnt = pulse_len;
        end else begin
          next_state = MPC_ST_IDLE;
        end
      end
      MPC_ST_GAP: begin
        if (!irq_func || !keep_going) begin
          next_state = MPC_ST_IDLE;
        end else if (cnt != '0) begin
          next_cnt = cnt - 1'b1;
        end else begin
          next_state = MPC_ST_PULSE;
          next_cnt = pulse_len;
        end
      end
      default: next_state = MPC_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state <= MPC_ST_IDLE;
      cnt <= '0;
      src_prev <= 1'b0;
      pending <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      src_prev <= next_src_prev;
      pending <= next_pending;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // multipurpose pin drive, bit clock and digital microphone capture
  logic mp_out;
  logic mp_oe;
  logic bclk_ext;
  logic dmic_clk_prev;
  logic dmic_rise;
  logic dmic_fall;
  logic dmic_valid;
  logic next_mp_out;
  logic next_mp_oe;
  logic next_bclk_ext;
  logic next_dmic_rise;
  logic next_dmic_fall;
  logic next_dmic_valid;
  logic dmic_mode;

  assign dmic_mode = (func == MPC_F_DMIC_A) || (func == MPC_F_DMIC_B) || (func == MPC_F_DMIC_C);

  always_comb begin
    next_mp_out = 1'b0;
    next_mp_oe = 1'b0;
    next_bclk_ext = 1'b0;
    next_dmic_rise = dmic_rise;
    next_dmic_fall = dmic_fall;
    next_dmic_valid = 1'b0;
    if (irq_func) begin
      next_mp_oe = 1'b1;
      next_mp_out = (state == MPC_ST_PULSE);
    end else begin
      case (func)
        MPC_F_GP_OUT: begin
          next_mp_oe = 1'b1;
          next_mp_out = pin_two_reg[MPC_GP_OUT_BIT];
        end
        MPC_F_BCLK: begin
          // bit clock passes through one flop, so it lags the serial bus by a cycle
          next_mp_oe = aux_reg[MPC_BCLK_DIR_BIT];
          next_mp_out = aux_reg[MPC_BCLK_DIR_BIT] & bclk_int_in;
          next_bclk_ext = ~aux_reg[MPC_BCLK_DIR_BIT] & multipurpose_pin_two_in;
        end
        // disabled, reserved, input, microphone and unlisted codes leave the pin floating
        default: next_mp_oe = 1'b0;
      endcase
    end
    if (dmic_mode) begin
      if (dmic_clk_in && !dmic_clk_prev) begin
        next_dmic_rise = multipurpose_pin_two_in;
      end
      if (!dmic_clk_in && dmic_clk_prev) begin
        next_dmic_fall = multipurpose_pin_two_in;
        next_dmic_valid = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      mp_out <= 1'b0;
      mp_oe <= 1'b0;
      bclk_ext <= 1'b0;
      dmic_clk_prev <= 1'b0;
      dmic_rise <= 1'b0;
      dmic_fall <= 1'b0;
      dmic_valid <= 1'b0;
    end else begin
      mp_out <= next_mp_out;
      mp_oe <= next_mp_oe;
      bclk_ext <= next_bclk_ext;
      dmic_clk_prev <= dmic_clk_in;
      dmic_rise <= next_dmic_rise;
      dmic_fall <= next_dmic_fall;
      dmic_valid <= next_dmic_valid;
    end
  end

  assign multipurpose_pin_two_out = mp_out;
  assign multipurpose_pin_two_oe_out = mp_oe;
  assign bclk_ext_out = bclk_ext;
  assign dmic_rise_data_out = dmic_rise;
  assign dmic_fall_data_out = dmic_fall;
  assign dmic_valid_out = dmic_valid;

  ////////////////////////////////////////////////////////////////////////////
  // control-bus pins: index 0 is the data line, index 1 the clock line
  logic [1:0] od_role [2];
  logic [1:0] od_rel;
  logic [1:0] od_bus_pull;
  logic [1:0] od_oe;
  logic [1:0] od_out;

  assign od_role[0] = reuse_reg[MPC_DATA_ROLE_HI:MPC_DATA_ROLE_LO];
  assign od_role[1] = reuse_reg[MPC_CLK_ROLE_HI:MPC_CLK_ROLE_LO];
  assign od_rel = {reuse_reg[MPC_CLK_OUT_BIT], reuse_reg[MPC_DATA_OUT_BIT]};
  assign od_bus_pull = {bus_clk_pull_in, bus_data_pull_in};

  for (genvar i = 0; i < 2; i++) begin : g_od
    logic next_oe;
    logic next_out;
    always_comb begin
      next_out = 1'b0;
      next_oe = od_bus_pull[i];
      od_level[i] = 1'b0;
      if (spi_select_in) begin
        // role 11 is never written; it falls back to plain bus function
        if (od_role[i] == MPC_ROLE_OUT) begin
          next_oe = ~od_rel[i];
        end else if (od_role[i] == MPC_ROLE_IN) begin
          od_level[i] = od_pin_in[i];
        end
      end
    end
    always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
        od_oe[i] <= 1'b0;
        od_out[i] <= 1'b0;
      end else begin
        od_oe[i] <= next_oe;
        od_out[i] <= next_out;
      end
    end
  end

  assign data_pin_oe_out = od_oe[0];
  assign data_pin_out = od_out[0];
  assign clk_pin_oe_out = od_oe[1];
  assign clk_pin_out = od_out[1];

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  sequence rd_pin_two_s;
    reg_rd_in && reg_addr_in == MPC_OFS_PIN_TWO;
  endsequence
  sequence rd_reuse_in_s;
    reg_rd_in && reg_addr_in == MPC_OFS_REUSE && spi_select_in && od_role[0] == MPC_ROLE_IN;
  endsequence
  sequence pulse_end_s;
    state == MPC_ST_PULSE && cnt == '0 && irq_func;
  endsequence

  gp_input_float_a: assert property (func == MPC_F_GP_IN |=> !multipurpose_pin_two_oe_out)
    else $error("pin driven in input mode");
  reset_disabled_a: assert property ($fell(rst_in) |-> func == MPC_F_DISABLED && state == MPC_ST_IDLE)
    else $error("function field not cleared by reset");
  gp_output_level_a: assert property (func == MPC_F_GP_OUT |=>
      multipurpose_pin_two_oe_out && multipurpose_pin_two_out == $past(pin_two_reg[MPC_GP_OUT_BIT]))
    else $error("general-purpose output level wrong");
  pin_level_read_a: assert property (rd_pin_two_s |=> reg_rdata_out[MPC_GP_IN_BIT] == $past(multipurpose_pin_two_in))
    else $error("pin level read back wrong");
  single_pulse_end_a: assert property (pulse_end_s ##0 !repeat_mode |=> state == MPC_ST_IDLE)
    else $error("single pulse did not end");
  repeat_pulse_a: assert property (pulse_end_s ##0 (repeat_mode && pending && !irq_flags_read_in)
      |=> state == MPC_ST_GAP ##1 (state == MPC_ST_GAP || state == MPC_ST_IDLE))
    else $error("repeat mode did not continue");
  irq_drive_a: assert property (irq_func && state == MPC_ST_PULSE |=> multipurpose_pin_two_oe_out && multipurpose_pin_two_out)
    else $error("interrupt pulse not on pin");
  irq_start_a: assert property (state == MPC_ST_IDLE && irq_event |=> state == MPC_ST_PULSE ##1 multipurpose_pin_two_out)
    else $error("interrupt event did not start a pulse");
  data_pull_low_a: assert property (spi_select_in && od_role[0] == MPC_ROLE_OUT && !od_rel[0]
      |=> data_pin_oe_out && !data_pin_out)
    else $error("data line not pulled low");
  bus_mode_pass_a: assert property (!spi_select_in |=> data_pin_oe_out == $past(bus_data_pull_in)
      && clk_pin_oe_out == $past(bus_clk_pull_in))
    else $error("bus function not kept outside SPI mode");
  data_level_read_a: assert property (rd_reuse_in_s |=> reg_rdata_out[MPC_DATA_IN_BIT] == $past(data_pin_in))
    else $error("data line level read back wrong");
  unlisted_idle_a: assert property (func == MPC_F_UNLISTED |=> !multipurpose_pin_two_oe_out)
    else $error("unlisted code drives the pin");
  dmic_capture_a: assert property (dmic_mode && !dmic_clk_in && dmic_clk_prev
      |=> dmic_valid_out && dmic_fall_data_out == $past(multipurpose_pin_two_in))
    else $error("microphone falling-edge sample lost");
endmodule

// File: mpc_pin_partner.sv
`timescale 1ns/1ps
module mpc_pin_partner (
  input wire logic clk_sys_in,
  input wire logic mp_out_in,
  input wire logic mp_oe_in,
  input wire logic mp_drive_in,
  input wire logic mp_level_in,
  input wire logic data_oe_in,
  input wire logic clk_oe_in,
  input wire logic data_pull_in,
  input wire logic clk_pull_in,
  output logic mp_pin_out,
  output logic data_line_out,
  output logic clk_line_out
);
  logic churn = 1'b0;
  // a floating pin has no defined level, so show a changing pattern, never the last value
  always @(posedge clk_sys_in) begin
    churn <= ~churn;
  end
  assign mp_pin_out = mp_oe_in ? mp_out_in : (mp_drive_in ? mp_level_in : churn);
  // open drain: any party pulls low, only the external pullup makes the high level
  assign data_line_out = ~(data_oe_in | data_pull_in);
  assign clk_line_out = ~(clk_oe_in | clk_pull_in);
endmodule

// File: codec_multipurpose_pin_control_tb.sv
`timescale 1ns/1ps
module codec_multipurpose_pin_control_tb;
  import mpc_pkg::*;
  logic clk_sys_in = 1'b0, rst_in = 1'b1, wr = 1'b0, rd = 1'b0, flags_rd = 1'b0, bclk_int = 1'b0;
  logic mic_clk = 1'b0, spi = 1'b0, dpull = 1'b0, cpull = 1'b0, mp_drv = 1'b1, mp_lvl = 1'b0;
  logic xdpull = 1'b0, xcpull = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [3:0] src = 4'h0;
  logic bclk_ext, rise_d, fall_d, valid, mp_pin, mp_out, mp_oe;
  logic data_line, data_oe, clk_line, clk_oe, dout, cout;
  int n_fail = 0, samples_checked = 0, n, w;
  logic [3:0] codes [6] = '{4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hF};
  logic [3:0] masks [6] = '{4'h3, 4'hF, 4'hC, 4'h7, 4'h8, 4'h2};

  initial begin
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  mpc_pin_control #(.PULSE_CYCLES(8), .JACK_PULSE_CYCLES(6)) u_mpc_pin_control (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .headset_irq_in(src[0]),
    .button_irq_in(src[1]), .short_irq_in(src[2]), .noise_irq_in(src[3]),
    .irq_flags_read_in(flags_rd), .bclk_int_in(bclk_int), .bclk_ext_out(bclk_ext),
    .dmic_clk_in(mic_clk), .dmic_rise_data_out(rise_d), .dmic_fall_data_out(fall_d),
    .dmic_valid_out(valid), .multipurpose_pin_two_in(mp_pin), .multipurpose_pin_two_out(mp_out),
    .multipurpose_pin_two_oe_out(mp_oe), .spi_select_in(spi), .bus_data_pull_in(dpull),
    .bus_clk_pull_in(cpull), .data_pin_in(data_line), .data_pin_out(dout), .data_pin_oe_out(data_oe),
    .clk_pin_in(clk_line), .clk_pin_out(cout), .clk_pin_oe_out(clk_oe));

  mpc_pin_partner u_mpc_pin_partner (
    .clk_sys_in(clk_sys_in), .mp_out_in(mp_out), .mp_oe_in(mp_oe), .mp_drive_in(mp_drv),
    .mp_level_in(mp_lvl), .data_oe_in(data_oe), .clk_oe_in(clk_oe), .data_pull_in(xdpull),
    .clk_pull_in(xcpull), .mp_pin_out(mp_pin), .data_line_out(data_line), .clk_line_out(clk_line));

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys_in);
    #1;
  endtask

  // reserved function code is never written from here; reserved bits only by the all-ones write to the aux register
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_in);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_in);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  // waits a bounded time for the pin to rise, then counts the high cycles
  task automatic pulse_len(output int k);
    int t;
    k = 0;
    t = 0;
    while (mp_out !== 1'b1 && t < 20) begin
      cyc(1);
      t++;
    end
    while (mp_out === 1'b1 && k < 40) begin
      cyc(1);
      k++;
    end
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    n_fail++;
    stop_test();
  end

  initial begin
    cyc(10);
    rst_in <= 1'b0;
    rd_chk(MPC_OFS_PIN_TWO, 8'h00);
    rd_chk(MPC_OFS_REUSE, 8'h00);
    chk({6'h00, mp_oe, data_oe | clk_oe}, 8'h00);
    wr_reg(MPC_OFS_AUX, 8'hFF);
    rd_chk(MPC_OFS_AUX, 8'h01);
    wr_reg(8'h65, 8'hFF);
    rd_chk(8'h65, 8'h00);
    // general-purpose output then input
    // the far side lets go while the block drives, so the level read back is the block's own
    mp_drv <= 1'b0;
    wr_reg(MPC_OFS_PIN_TWO, 8'h48);
    cyc(2);
    chk({6'h00, mp_oe, mp_out}, 8'h03);
    rd_chk(MPC_OFS_PIN_TWO, 8'h4C);
    wr_reg(MPC_OFS_PIN_TWO, 8'h40);
    cyc(2);
    chk({6'h00, mp_oe, mp_out}, 8'h02);
    rd_chk(MPC_OFS_PIN_TWO, 8'h40);
    mp_lvl <= 1'b1;
    mp_drv <= 1'b1;
    wr_reg(MPC_OFS_PIN_TWO, 8'h30);
    cyc(2);
    chk({7'h00, mp_oe}, 8'h00);
    rd_chk(MPC_OFS_PIN_TWO, 8'h34);
    mp_lvl <= 1'b0;
    // quiet codes keep the pin off even with every source active
    wr_reg(MPC_OFS_PIN_TWO, 8'hE0);
    src <= 4'hF;
    cyc(12);
    chk({6'h00, mp_oe, mp_out}, 8'h00);
    wr_reg(MPC_OFS_PIN_TWO, 8'h00);
    cyc(12);
    chk({6'h00, mp_oe, mp_out}, 8'h00);
    src <= 4'h0;
    // every interrupt code except jack detect 0010 against every source
    for (int c = 0; c < 6; c++) begin
      for (int s = 0; s < 4; s++) begin
        wr_reg(MPC_OFS_PIN_TWO, {codes[c], 4'h0});
        cyc(2);
        chk({7'h00, mp_oe}, 8'h01);
        @(posedge clk_sys_in);
        src <= 4'h1 << s;
        pulse_len(n);
        chk(8'(n), masks[c][s] ? 8'h08 : 8'h00);
        @(posedge clk_sys_in);
        src <= 4'h0;
        cyc(12);
      end
    end
    // single pulse: a held source gives no second pulse
    wr_reg(MPC_OFS_PIN_TWO, 8'h90);
    src <= 4'h1;
    pulse_len(n);
    chk(8'(n), 8'h08);
    pulse_len(n);
    chk(8'(n), 8'h00);
    src <= 4'h0;
    wr_reg(MPC_OFS_PIN_TWO, 8'h20);
    cyc(2);
    src <= 4'h1;
    pulse_len(n);
    chk(8'(n), 8'h06);
    src <= 4'h0;
    // repeat mode runs until the flag register is read
    wr_reg(MPC_OFS_PIN_TWO, 8'h92);
    cyc(2);
    src <= 4'h1;
    pulse_len(n);
    chk(8'(n), 8'h08);
    pulse_len(n);
    chk(8'(n), 8'h08);
    flags_rd <= 1'b1;
    src <= 4'h0;
    @(posedge clk_sys_in);
    flags_rd <= 1'b0;
    cyc(10);
    pulse_len(n);
    chk(8'(n), 8'h00);
    // bit clock out and in
    wr_reg(MPC_OFS_AUX, 8'h01);
    wr_reg(MPC_OFS_PIN_TWO, 8'h80);
    bclk_int <= 1'b1;
    cyc(3);
    chk({6'h00, mp_oe, mp_out}, 8'h03);
    bclk_int <= 1'b0;
    cyc(3);
    chk({6'h00, mp_oe, mp_out}, 8'h02);
    wr_reg(MPC_OFS_AUX, 8'h00);
    mp_lvl <= 1'b1;
    cyc(3);
    chk({6'h00, mp_oe, bclk_ext}, 8'h01);
    // microphone data taken on both clock edges
    for (int c = 5; c < 8; c++) begin
      wr_reg(MPC_OFS_PIN_TWO, {4'(c), 4'h0});
      // levels alternate from code to code so that a stuck sample shows up
      mp_lvl <= c[0];
      cyc(2);
      mic_clk <= 1'b1;
      cyc(4);
      mp_lvl <= ~c[0];
      cyc(2);
      mic_clk <= 1'b0;
      w = 0;
      while (valid !== 1'b1 && w < 10) begin
        cyc(1);
        w++;
      end
      chk({5'h00, valid, rise_d, fall_d}, {5'h00, 1'b1, c[0], ~c[0]});
      chk({7'h00, mp_oe}, 8'h00);
    end
    // control-bus pins outside and inside SPI mode
    dpull <= 1'b1;
    cyc(2);
    chk({6'h00, data_oe, data_line}, 8'h02);
    dpull <= 1'b0;
    wr_reg(MPC_OFS_REUSE, 8'h88);
    cyc(2);
    chk({6'h00, data_oe, clk_oe}, 8'h00);
    spi <= 1'b1;
    cyc(3);
    chk({4'h0, data_oe, data_line, clk_oe, clk_line}, 8'h0A);
    wr_reg(MPC_OFS_REUSE, 8'hAA);
    cyc(2);
    chk({4'h0, data_oe, data_line, clk_oe, clk_line}, 8'h05);
    rd_chk(MPC_OFS_REUSE, 8'hAA);
    wr_reg(MPC_OFS_REUSE, 8'h44);
    xdpull <= 1'b1;
    cyc(2);
    rd_chk(MPC_OFS_REUSE, 8'h45);
    xdpull <= 1'b0;
    xcpull <= 1'b1;
    cyc(2);
    rd_chk(MPC_OFS_REUSE, 8'h54);
    chk({6'h00, data_oe, clk_oe}, 8'h00);
    chk({6'h00, dout, cout}, 8'h00);
    stop_test();
  end
endmodule
